// ---- shared/dac_cfg_pkg.sv ----
// constants for the octal converter configuration control
// assumes a single 100 MHz clock domain and a plain register port
package dac_cfg_pkg;
    localparam int NCH = 8;
    localparam int DW = 16;
    localparam int AW = 5;
    localparam int GROUP_SIZE = 4;
    localparam int CLK_MHZ = 100;
    localparam logic [4:0] ADDR_CFG = 5'h00;
    localparam logic [4:0] ADDR_BCAST = 5'h07;
    localparam logic [1:0] SPACE_CTRL = 2'h0;
    localparam logic [1:0] SPACE_DAC = 2'h1;
    localparam logic [1:0] SPACE_ZERO = 2'h2;
    localparam logic [1:0] SPACE_GAIN = 2'h3;
    localparam int BIT_RBSEL = 15;
    localparam int BIT_SYNC_LOAD = 14;
    localparam int BIT_RST = 13;
    localparam int BIT_PWRDN_A = 12;
    localparam int BIT_PWRDN_B = 11;
    localparam int BIT_CAL_EN = 10;
    localparam int BIT_RSVD = 9;
    localparam logic [15:0] CFG_RESET = 16'h8000;
    localparam logic [15:0] GAIN_RESET = 16'h8000;
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam int GAIN_SHIFT = 15;
    localparam int CAL_LAT = 3;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'h0,
        CAL_MUL = 2'h1,
        CAL_ADD = 2'h3
    } cal_state_e;
endpackage : dac_cfg_pkg

// ---- design/cal_engine.sv ----
// gain and zero correction of one channel word
// assumes start only while idle; clear_in is a synchronous reset
module cal_engine #(
    parameter int DW = dac_cfg_pkg::DW
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic start_in,
    input wire logic [DW-1:0] data_in,
    input wire logic [DW-1:0] gain_in,
    input wire logic [DW-1:0] zero_in,
    output logic busy_out,
    output logic done_out,
    output logic [DW-1:0] result_out
);
    dac_cfg_pkg::cal_state_e state_r;
    logic [DW-1:0] data_r;
    logic [DW-1:0] gain_r;
    logic [DW-1:0] zero_r;
    logic [2*DW-1:0] prod_r;
    logic signed [DW+1:0] sum;

    always_comb begin
        sum = $signed({1'b0, prod_r[2*DW-1:dac_cfg_pkg::GAIN_SHIFT]})
            + $signed({{2{zero_r[DW-1]}}, zero_r});
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= dac_cfg_pkg::CAL_IDLE;
            data_r <= '0;
            gain_r <= '0;
            zero_r <= '0;
            prod_r <= '0;
            done_out <= 1'b0;
            result_out <= '0;
        end else if (clear_in) begin
            state_r <= dac_cfg_pkg::CAL_IDLE;
            done_out <= 1'b0;
            result_out <= '0;
        end else begin
            done_out <= 1'b0;
            case (state_r)
                dac_cfg_pkg::CAL_IDLE: begin
                    if (start_in) begin
                        data_r <= data_in;
                        gain_r <= gain_in;
                        zero_r <= zero_in;
                        state_r <= dac_cfg_pkg::CAL_MUL;
                    end
                end
                dac_cfg_pkg::CAL_MUL: begin
                    prod_r <= data_r * gain_r;
                    state_r <= dac_cfg_pkg::CAL_ADD;
                end
                dac_cfg_pkg::CAL_ADD: begin
                    if (sum < 0) begin
                        result_out <= '0;
                    end else if (sum[DW]) begin
                        result_out <= '1;
                    end else begin
                        result_out <= sum[DW-1:0];
                    end
                    done_out <= 1'b1;
                    state_r <= dac_cfg_pkg::CAL_IDLE;
                end
                default: begin
                    state_r <= dac_cfg_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    assign busy_out = (state_r != dac_cfg_pkg::CAL_IDLE);

    a_cal_latency: assert property (@(posedge clk_in) disable iff (!nrst_in || clear_in)
        start_in && !busy_out |-> ##3 done_out)
        else $error("correction result late");
endmodule : cal_engine

// ---- design/latch_bank.sv ----
// output latches with per-channel written-since-load flags
// assumes data_in is stable in any cycle where load_in is high
module latch_bank #(
    parameter int NCH = dac_cfg_pkg::NCH,
    parameter int DW = dac_cfg_pkg::DW
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic [NCH-1:0] mark_in,
    input wire logic load_in,
    input wire logic [NCH*DW-1:0] data_in,
    output logic [NCH*DW-1:0] latch_out,
    output logic [NCH-1:0] dirty_out
);
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    latch_out[g*DW +: DW] <= dac_cfg_pkg::DATA_RESET;
                    dirty_out[g] <= 1'b0;
                end else if (clear_in) begin
                    latch_out[g*DW +: DW] <= dac_cfg_pkg::DATA_RESET;
                    dirty_out[g] <= 1'b0;
                end else begin
                    if (load_in && dirty_out[g]) begin
                        latch_out[g*DW +: DW] <= data_in[g*DW +: DW];
                    end
                    if (mark_in[g]) begin
                        dirty_out[g] <= 1'b1;
                    end else if (load_in) begin
                        dirty_out[g] <= 1'b0;
                    end
                end
            end

            a_clean_holds: assert property (@(posedge clk_in) disable iff (!nrst_in)
                !clear_in && !(load_in && dirty_out[g])
                |=> $stable(latch_out[g*DW +: DW]))
                else $error("latch changed without a due load");
        end
    endgenerate
endmodule : latch_bank

// ---- design/octal_dac_config_control.sv ----
// configuration control of the eight-channel converter
// assumes synchronous inputs, one clock, a register port with read data one cycle late
// Function
// - readback select 0 reads input data, 1 reads converted data; resets to 1.
// - with correction on, input register keeps raw word, data register the result.
// - sync load with load pin high updates latches after write and correction finish.
// - a load reloads only channels written since the last load; others hold.
// - the sync load bit clears itself once its latch update is done.
// - with correction off, sync load updates the latches at once.
// - while the load pin is low, sync load writes are ignored.
// - software reset acts as a hardware reset and reads 0 afterwards.
// - group A power-down floats channels 0 to 3; register port stays live.
// - group B power-down floats channels 4 to 7; register port stays live.
// - correction on passes data through gain and zero of its channel.
// - correction off copies data unchanged at once into the data register.
// - bit 9 is reserved: writes ignored, reads return 0.
// - after any reset the configuration word reads 8000h.
//
// The implementer's own choices: the register offsets and strobed register access.
module octal_dac_config_control #(
    parameter int NCH = dac_cfg_pkg::NCH,
    parameter int DW = dac_cfg_pkg::DW
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [dac_cfg_pkg::AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic async_load_pin_in,
    output logic [DW-1:0] rdata_out,
    output logic [NCH*DW-1:0] latch_out,
    output logic [NCH-1:0] buf_oe_n_out,
    output logic group_a_powerdown_out,
    output logic group_b_powerdown_out
);
    generate
        if (NCH != 8 || DW != 16) begin : g_bad_size
            $error("address map serves eight 16-bit channels only");
        end
    endgenerate

    logic rb_sel_r;
    logic sync_latch_load_r;
    logic srst_r;
    logic cal_en_r;
    logic [DW-1:0] input_r [NCH];
    logic [DW-1:0] dac_r [NCH];
    logic [DW-1:0] gain_r [NCH];
    logic [DW-1:0] zero_r [NCH];
    logic [NCH-1:0] cal_pend_r;
    logic [2:0] cal_ch_r;
    logic [NCH-1:0] wmask;
    logic [NCH-1:0] mark;
    logic [NCH-1:0] dirty;
    logic [NCH*DW-1:0] dac_flat;
    logic [2:0] pick;
    logic wr_cfg;
    logic cal_start;
    logic cal_busy;
    logic cal_done;
    logic [DW-1:0] cal_result;
    logic load_fire;
    logic load_go;
    logic [DW-1:0] cfg_word;
    logic [DW-1:0] rdata_nxt;

    // channels hit by an address, broadcast included
    function automatic logic [7:0] chan_sel(input logic [4:0] a);
        logic [7:0] m;
        m = 8'h00;
        if (a == dac_cfg_pkg::ADDR_BCAST) begin
            m = 8'hFF;
        end else if (a[4:3] == dac_cfg_pkg::SPACE_DAC) begin
            m[a[2:0]] = 1'b1;
        end
        return m;
    endfunction : chan_sel

    // lowest pending channel
    function automatic logic [2:0] first_set(input logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_set

    assign wr_cfg = wr_in && (addr_in == dac_cfg_pkg::ADDR_CFG);
    assign wmask = wr_in ? chan_sel(addr_in) : 8'h00;
    assign pick = first_set(cal_pend_r);
    assign cal_start = (cal_pend_r != '0) && !cal_busy;
    assign load_fire = sync_latch_load_r && async_load_pin_in && !cal_busy && !cal_done
        && (cal_pend_r == '0);
    assign load_go = load_fire || !async_load_pin_in;

    always_comb begin
        mark = cal_en_r ? '0 : wmask;
        if (cal_done) begin
            mark[cal_ch_r] = 1'b1;
        end
        for (int i = 0; i < NCH; i++) begin
            dac_flat[i*DW +: DW] = dac_r[i];
        end
    end

    // configuration bits
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rb_sel_r <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_RBSEL];
            cal_en_r <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_CAL_EN];
            group_a_powerdown_out <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_PWRDN_A];
            group_b_powerdown_out <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_PWRDN_B];
            srst_r <= 1'b0;
        end else if (srst_r) begin
            rb_sel_r <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_RBSEL];
            cal_en_r <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_CAL_EN];
            group_a_powerdown_out <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_PWRDN_A];
            group_b_powerdown_out <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::BIT_PWRDN_B];
            srst_r <= 1'b0;
        end else if (wr_cfg) begin
            rb_sel_r <= wdata_in[dac_cfg_pkg::BIT_RBSEL];
            cal_en_r <= wdata_in[dac_cfg_pkg::BIT_CAL_EN];
            group_a_powerdown_out <= wdata_in[dac_cfg_pkg::BIT_PWRDN_A];
            group_b_powerdown_out <= wdata_in[dac_cfg_pkg::BIT_PWRDN_B];
            srst_r <= wdata_in[dac_cfg_pkg::BIT_RST];
        end
    end

    // sync load request
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_latch_load_r <= 1'b0;
        end else if (srst_r) begin
            sync_latch_load_r <= 1'b0;
        end else if (wr_cfg && wdata_in[dac_cfg_pkg::BIT_SYNC_LOAD] && async_load_pin_in) begin
            sync_latch_load_r <= 1'b1;
        end else if (load_fire || !async_load_pin_in) begin
            sync_latch_load_r <= 1'b0;
        end
    end

    // output buffer enables, low while driving
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            buf_oe_n_out <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                buf_oe_n_out[i] <= (i < dac_cfg_pkg::GROUP_SIZE)
                    ? group_a_powerdown_out : group_b_powerdown_out;
            end
        end
    end

    // channel input, gain and zero registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NCH; i++) begin
                input_r[i] <= dac_cfg_pkg::DATA_RESET;
                gain_r[i] <= dac_cfg_pkg::GAIN_RESET;
                zero_r[i] <= dac_cfg_pkg::ZERO_RESET;
            end
        end else if (srst_r) begin
            for (int i = 0; i < NCH; i++) begin
                input_r[i] <= dac_cfg_pkg::DATA_RESET;
                gain_r[i] <= dac_cfg_pkg::GAIN_RESET;
                zero_r[i] <= dac_cfg_pkg::ZERO_RESET;
            end
        end else if (wr_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (wmask[i]) begin
                    input_r[i] <= wdata_in;
                end
            end
            if (addr_in[4:3] == dac_cfg_pkg::SPACE_ZERO) begin
                zero_r[addr_in[2:0]] <= wdata_in;
            end
            if (addr_in[4:3] == dac_cfg_pkg::SPACE_GAIN) begin
                gain_r[addr_in[2:0]] <= wdata_in;
            end
        end
    end

    // converted data registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NCH; i++) begin
                dac_r[i] <= dac_cfg_pkg::DATA_RESET;
            end
        end else if (srst_r) begin
            for (int i = 0; i < NCH; i++) begin
                dac_r[i] <= dac_cfg_pkg::DATA_RESET;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!cal_en_r && wmask[i]) begin
                    dac_r[i] <= wdata_in;
                end else if (cal_done && (cal_ch_r == 3'(i))) begin
                    dac_r[i] <= cal_result;
                end
            end
        end
    end

    // correction queue, a new write wins over the start clear
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cal_pend_r <= '0;
            cal_ch_r <= '0;
        end else if (srst_r) begin
            cal_pend_r <= '0;
            cal_ch_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cal_en_r && wmask[i]) begin
                    cal_pend_r[i] <= 1'b1;
                end else if (cal_start && (pick == 3'(i))) begin
                    cal_pend_r[i] <= 1'b0;
                end
            end
            if (cal_start) begin
                cal_ch_r <= pick;
            end
        end
    end

    cal_engine #(
        .DW(DW)
    ) u_cal (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(srst_r),
        .start_in(cal_start),
        .data_in(input_r[pick]),
        .gain_in(gain_r[pick]),
        .zero_in(zero_r[pick]),
        .busy_out(cal_busy),
        .done_out(cal_done),
        .result_out(cal_result)
    );

    latch_bank #(
        .NCH(NCH),
        .DW(DW)
    ) u_latch (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(srst_r),
        .mark_in(mark),
        .load_in(load_go),
        .data_in(dac_flat),
        .latch_out(latch_out),
        .dirty_out(dirty)
    );

    // register read path
    always_comb begin
        cfg_word = '0;
        cfg_word[dac_cfg_pkg::BIT_RBSEL] = rb_sel_r;
        cfg_word[dac_cfg_pkg::BIT_SYNC_LOAD] = sync_latch_load_r;
        cfg_word[dac_cfg_pkg::BIT_RST] = srst_r;
        cfg_word[dac_cfg_pkg::BIT_PWRDN_A] = group_a_powerdown_out;
        cfg_word[dac_cfg_pkg::BIT_PWRDN_B] = group_b_powerdown_out;
        cfg_word[dac_cfg_pkg::BIT_CAL_EN] = cal_en_r;
        cfg_word[dac_cfg_pkg::BIT_RSVD] = 1'b0;
        rdata_nxt = '0;
        case (addr_in[4:3])
            dac_cfg_pkg::SPACE_CTRL: begin
                if (addr_in == dac_cfg_pkg::ADDR_CFG) begin
                    rdata_nxt = cfg_word;
                end
            end
            dac_cfg_pkg::SPACE_DAC: begin
                rdata_nxt = rb_sel_r ? dac_r[addr_in[2:0]] : input_r[addr_in[2:0]];
            end
            dac_cfg_pkg::SPACE_ZERO: begin
                rdata_nxt = zero_r[addr_in[2:0]];
            end
            dac_cfg_pkg::SPACE_GAIN: begin
                rdata_nxt = gain_r[addr_in[2:0]];
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= rdata_nxt;
        end else begin
            rdata_out <= '0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_readback_select: assert property (rd_in && addr_in[4:3] == dac_cfg_pkg::SPACE_DAC
        |=> rdata_out == $past(rb_sel_r ? dac_r[addr_in[2:0]] : input_r[addr_in[2:0]]))
        else $error("channel readback source wrong");
    a_raw_input_kept: assert property (wr_in && wmask[0] && !srst_r
        |=> input_r[0] == $past(wdata_in))
        else $error("input register lost raw word");
    a_sync_load_clear: assert property (load_fire && !srst_r && !wr_cfg
        |=> !sync_latch_load_r)
        else $error("sync load bit did not clear");
    a_load_ignored_low: assert property (!async_load_pin_in && !sync_latch_load_r
        |=> !sync_latch_load_r)
        else $error("sync load taken while pin low");
    a_soft_reset: assert property (wr_cfg && wdata_in[dac_cfg_pkg::BIT_RST]
        && !srst_r |=> srst_r ##1 (cfg_word == dac_cfg_pkg::CFG_RESET && !srst_r))
        else $error("software reset did not act");
    a_group_a_float: assert property (group_a_powerdown_out |=> buf_oe_n_out[3:0] == 4'hF)
        else $error("group a still driving");
    a_group_b_float: assert property (group_b_powerdown_out |=> buf_oe_n_out[7:4] == 4'hF)
        else $error("group b still driving");
    a_direct_copy: assert property (!cal_en_r && wmask[3] && !srst_r
        |=> dac_r[3] == $past(wdata_in))
        else $error("data register not copied");
    a_reserved_zero: assert property (rd_in && addr_in == dac_cfg_pkg::ADDR_CFG
        |=> rdata_out[dac_cfg_pkg::BIT_RSVD] == 1'b0)
        else $error("reserved bit reads one");
    a_immediate_load: assert property (wr_cfg && wdata_in[dac_cfg_pkg::BIT_SYNC_LOAD]
        && async_load_pin_in && !cal_en_r && !cal_busy && !cal_done && cal_pend_r == '0
        && !srst_r |=> load_fire || !async_load_pin_in)
        else $error("sync load delayed");

    c_sync_load: cover property (load_fire && dirty != '0);
    c_cal_done: cover property (cal_done && sync_latch_load_r);
    c_soft_reset: cover property (srst_r);
    c_broadcast: cover property (wr_in && addr_in == dac_cfg_pkg::ADDR_BCAST);
endmodule : octal_dac_config_control

// ---- test/host_model.sv ----
// host side of the register port: word writes and reads
// assumes read data stand only in the cycle after the read strobe
module host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic [dac_cfg_pkg::AW-1:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_out = 5'h00;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one whole word per access; released lines show the inverse
    task automatic write_word(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : write_word
    task automatic read_word(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : read_word
endmodule : host_model

// ---- test/octal_dac_config_control_tb.sv ----
// self-checking bench of the converter configuration control
// assumes the host model drives the register port
module octal_dac_config_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic pin = 1'b1;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [127:0] latch;
    logic [7:0] oe_n;
    logic pwrdn_a;
    logic pwrdn_b;
    logic [15:0] v;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clk_in = ~clk_in;
    host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    octal_dac_config_control dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .async_load_pin_in(pin),
        .rdata_out(rdata), .latch_out(latch), .buf_oe_n_out(oe_n),
        .group_a_powerdown_out(pwrdn_a), .group_b_powerdown_out(pwrdn_b));
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic t_reset_and_reserved();
        host.read_word(5'h00, v);
        chk("config after reset", 16'h8000, v);
        host.write_word(5'h00, 16'h8200);
        host.read_word(5'h00, v);
        chk("reserved bit", 16'h8000, v);
    endtask : t_reset_and_reserved
    task automatic t_correction();
        host.write_word(5'h18, 16'h4000);
        host.write_word(5'h10, 16'h0010);
        host.write_word(5'h00, 16'h8400);
        host.write_word(5'h08, 16'h1000);
        wait_cyc(8);
        host.read_word(5'h08, v);
        chk("corrected word", 16'h0810, v);
        host.write_word(5'h00, 16'h0400);
        host.read_word(5'h08, v);
        chk("raw input word", 16'h1000, v);
        host.write_word(5'h00, 16'h8000);
    endtask : t_correction
    task automatic t_sync_load();
        host.write_word(5'h09, 16'hABCD);
        host.read_word(5'h09, v);
        chk("copied word", 16'hABCD, v);
        chk("latch before load", 16'h0000, latch[16 +: 16]);
        host.write_word(5'h00, 16'hC000);
        wait_cyc(2);
        chk("latch 1 after load", 16'hABCD, latch[16 +: 16]);
        chk("latch 0 written earlier", 16'h0810, latch[0 +: 16]);
        chk("latch 2 untouched", 16'h0000, latch[32 +: 16]);
        host.read_word(5'h00, v);
        chk("load bit cleared", 16'h8000, v);
    endtask : t_sync_load
    task automatic t_pin_low();
        @(posedge clk_in);
        pin <= 1'b0;
        host.write_word(5'h00, 16'hC000);
        host.read_word(5'h00, v);
        chk("load bit ignored", 16'h8000, v);
        host.write_word(5'h0C, 16'h5A5A);
        wait_cyc(3);
        chk("latch 4 on pin low", 16'h5A5A, latch[64 +: 16]);
        @(posedge clk_in);
        pin <= 1'b1;
    endtask : t_pin_low
    task automatic t_powerdown();
        host.write_word(5'h00, 16'h9000);
        wait_cyc(2);
        chk("group a enables", 8'h0F, oe_n);
        chk("group a flags", 2'b10, {pwrdn_a, pwrdn_b});
        host.read_word(5'h00, v);
        chk("port live in power-down", 16'h9000, v);
        host.write_word(5'h00, 16'h8800);
        wait_cyc(2);
        chk("group b enables", 8'hF0, oe_n);
        chk("group b flags", 2'b01, {pwrdn_a, pwrdn_b});
        host.read_word(5'h00, v);
        chk("port live group b", 16'h8800, v);
    endtask : t_powerdown
    task automatic t_soft_reset();
        host.write_word(5'h07, 16'h1234);
        host.read_word(5'h0A, v);
        chk("broadcast word", 16'h1234, v);
        host.write_word(5'h00, 16'h2000);
        wait_cyc(3);
        host.read_word(5'h00, v);
        chk("config after soft reset", 16'h8000, v);
        chk("latches after soft reset", 128'h0, latch);
        chk("enables after soft reset", 8'h00, oe_n);
        host.read_word(5'h18, v);
        chk("gain after soft reset", 16'h8000, v);
    endtask : t_soft_reset
    task automatic t_hw_reset();
        host.write_word(5'h00, 16'h9400);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        wait_cyc(2);
        chk("enables in reset", 8'h00, oe_n);
        @(posedge clk_in);
        nrst_in <= 1'b1;
        host.read_word(5'h00, v);
        chk("config after hardware reset", 16'h8000, v);
    endtask : t_hw_reset
    initial begin
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset_and_reserved();
        t_correction();
        t_sync_load();
        t_pin_low();
        t_powerdown();
        t_soft_reset();
        t_hw_reset();
        stop_test();
    end
    initial begin
        #100us;
        n_errors++;
        stop_test();
    end
endmodule : octal_dac_config_control_tb
